/* File: core/cis_pkg.sv */
package cis_pkg;
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_CH    = 16;
  localparam int NUM_LINE  = 8;
  localparam int CH_W      = 4;
  localparam int LINE_W    = 3;
  localparam int UNIT_W    = 6;
  localparam int BYTE_W    = 8;
  localparam int DEFER_MAX = 3;
  localparam int DEFER_W   = 2;
  localparam int ADDR_W    = 12;

  // ----------------------------------------------------------------
  // timing: one channel scanned per tick, all within the period
  // ----------------------------------------------------------------
  localparam int CLK_HZ         = 50_000_000;
  localparam int SCAN_PERIOD_MS = 500;
  localparam int SCAN_TICK_CYC  = CLK_HZ / 1000 * SCAN_PERIOD_MS / NUM_CH;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CMD  = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;
  localparam logic [3:0]  PAGE_CH   = 4'h1;
  localparam logic [3:0]  PAGE_LINE = 4'h2;
  localparam logic [1:0]  CH_LVL    = 2'h0;
  localparam logic [1:0]  CH_SCAN   = 2'h1;
  localparam logic [1:0]  CH_STAT   = 2'h2;
  localparam logic [1:0]  CH_DEFER  = 2'h3;

  // ctrl and command fields
  localparam int CTRL_INIT_BIT   = 0;
  localparam int CTRL_LVLCHG_BIT = 1;
  localparam int CTRL_LOAD_BIT   = 2;
  localparam int CTRL_LINE_LSB   = 4;
  localparam int CMD_UNIT_LSB    = 4;
  localparam int CMD_OP_LSB      = 10;
  localparam int CMD_LVL_LSB     = 16;
  localparam int CMD_RET_LSB     = 24;

  // scan control byte bits and status byte bit
  localparam int SCAN_EN_BIT    = 0;
  localparam int SCAN_FLAG_BIT  = 1;
  localparam int SCAN_TERM_BIT  = 2;
  localparam int SCAN_START_BIT = 3;
  localparam int STAT_CHG_BIT   = 3;

  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [1:0] {
    CIS_OP_INTCTL,
    CIS_OP_CHINIT,
    CIS_OP_RSV2,
    CIS_OP_RSV3
  } cis_op_e;

  typedef enum logic {
    CIS_IRQ_IDLE,
    CIS_IRQ_WAIT
  } cis_irq_e;
endpackage

/* File: core/cis_core.sv */
`timescale 1ns/1ps
`default_nettype none
module cis_core
  import cis_pkg::*;
#(
  parameter int SCAN_TICK = SCAN_TICK_CYC
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       rstn_i,
  // apb slave
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [ADDR_W-1:0]          paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic                            pready_o,
  output logic [31:0]                     prdata_o,
  output logic                            pslverr_o,
  // unit address switch and adapter status pins
  input  wire logic [UNIT_W-1:0]          unit_sw_i,
  input  wire logic [NUM_LINE*BYTE_W-1:0] adp_status_i,
  // channel program events (same clock)
  input  wire logic                       ccb_start_i,
  input  wire logic                       ccb_done_i,
  input  wire logic                       ccb_intctl_i,
  input  wire logic [CH_W-1:0]            ccb_ch_i,
  input  wire logic                       blk_done_i,
  input  wire logic [CH_W-1:0]            blk_ch_i,
  input  wire logic                       program_interrupt_instruction_exec_i,
  input  wire logic [CH_W-1:0]            program_interrupt_instruction_ch_i,
  // host interrupt handshake
  input  wire logic                       irq_ack_i,
  input  wire logic                       irq_nak_i,
  output logic                            irq_req_o,
  output logic [BYTE_W-1:0]               irq_lvl_o,
  output logic [BYTE_W-1:0]               irq_ret_o,
  output logic [CH_W-1:0]                 irq_ch_o,
  // scan actions and adapter control
  output logic                            ccb_term_o,
  output logic                            prog_start_o,
  output logic [CH_W-1:0]                 scan_ch_o,
  output logic [NUM_LINE*BYTE_W-1:0]      adp_ctrl_o
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (SCAN_TICK < 1) begin : g_chk
    $error("SCAN_TICK must be at least one cycle");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [BYTE_W-1:0]          lvl_ff   [NUM_CH];  // interrupt level
  logic [BYTE_W-1:0]          ret_ff   [NUM_CH];  // host return chan
  logic [BYTE_W-1:0]          flags_ff [NUM_CH];  // scan control byte
  logic [BYTE_W-1:0]          mask_ff  [NUM_CH];  // change mask
  logic [BYTE_W-1:0]          saved_ff [NUM_CH];  // last recorded status
  logic [BYTE_W-1:0]          stat_ff  [NUM_CH];  // status byte 2
  logic [DEFER_W-1:0]         defer_ff [NUM_CH];  // deferred count
  logic [BYTE_W-1:0]          lctl_ff  [NUM_LINE];// line control byte
  logic [NUM_CH-1:0]          fresh_ff;           // new request pending
  logic [NUM_CH-1:0]          ccbz_ff;            // level zeroed in block
  logic [NUM_CH-1:0]          has_def;            // queue not empty
  logic [UNIT_W-1:0]          unit_s1_ff;         // switch sync stage 1
  logic [UNIT_W-1:0]          unit_ff;            // switch sync stage 2
  logic [NUM_LINE*BYTE_W-1:0] adp_s1_ff;          // status sync stage 1
  logic [NUM_LINE*BYTE_W-1:0] adp_s2_ff;          // status sync stage 2
  logic                       pready_ff;
  logic [31:0]                prdata_ff;
  logic                       pslverr_ff;
  logic [31:0]                rd_data;
  logic                       rd_ok;
  logic                       wr_en;
  logic                       hit_ch;
  logic                       hit_line;
  logic [CH_W-1:0]            a_ch;
  logic [1:0]                 a_reg;
  logic [LINE_W-1:0]          a_line;
  logic                       init_wr;
  logic                       lvlchg_wr;
  logic                       cmd_wr;
  logic [CH_W-1:0]            cmd_ch;
  cis_op_e                    cmd_op;
  logic [BYTE_W-1:0]          cmd_lvl;
  cis_irq_e                   irq_st_ff;
  logic                       irq_req_ff;
  logic [BYTE_W-1:0]          irq_lvl_ff;
  logic [BYTE_W-1:0]          irq_ret_ff;
  logic [CH_W-1:0]            irq_ch_ff;
  logic                       is_fresh_ff;        // current try is new
  logic                       armed_ff;           // retries enabled
  logic [CH_W-1:0]            rr_ff;              // retry start channel
  logic [CH_W:0]              pick_f;
  logic [CH_W:0]              pick_d;
  logic                       irq_done;
  logic [31:0]                tick_cnt_ff;
  logic                       tick;
  logic [CH_W-1:0]            sp_ff;              // channel under scan
  logic [BYTE_W-1:0]          live;
  logic                       chg;
  logic                       ccb_term_ff;
  logic                       prog_start_ff;
  logic [CH_W-1:0]            scan_ch_ff;
  logic                       load_ff;
  logic [LINE_W-1:0]          load_line_ff;
  logic [BYTE_W-1:0]          work_ff;            // working register
  logic [NUM_LINE*BYTE_W-1:0] adp_ctrl_ff;

  // first set bit at or after s, wrapping
  function automatic logic [CH_W:0] cis_pick(
    input logic [NUM_CH-1:0] v,
    input logic [CH_W-1:0]   s
  );
    logic [CH_W:0]   r;
    logic [CH_W-1:0] k;
    r = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      k = s + CH_W'(i);
      if (v[k]) begin
        r = {1'b1, k};
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // pins are asynchronous, stage 1 feeds stage 2 only
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      unit_s1_ff <= '0;
      unit_ff    <= '0;
      adp_s1_ff  <= '0;
      adp_s2_ff  <= '0;
    end else begin
      unit_s1_ff <= unit_sw_i;
      unit_ff    <= unit_s1_ff;
      adp_s1_ff  <= adp_status_i;
      adp_s2_ff  <= adp_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign wr_en     = psel_i & penable_i & pready_ff & pwrite_i;
  assign a_ch      = paddr_i[7:4];
  assign a_reg     = paddr_i[3:2];
  assign a_line    = paddr_i[4:2];
  assign hit_ch    = (paddr_i[11:8] == PAGE_CH) && (paddr_i[1:0] == 2'h0);
  assign hit_line  = (paddr_i[11:8] == PAGE_LINE) &&
                     (paddr_i[7:5] == 3'h0) && (paddr_i[1:0] == 2'h0);
  assign init_wr   = wr_en && (paddr_i == ADDR_CTRL) &&
                     pwdata_i[CTRL_INIT_BIT];
  assign lvlchg_wr = wr_en && (paddr_i == ADDR_CTRL) &&
                     pwdata_i[CTRL_LVLCHG_BIT];
  // foreign unit numbers are ignored
  assign cmd_wr    = wr_en && (paddr_i == ADDR_CMD) &&
                     (pwdata_i[CMD_UNIT_LSB +: UNIT_W] == unit_ff);
  assign cmd_ch    = pwdata_i[CH_W-1:0];
  assign cmd_op    = cis_op_e'(pwdata_i[CMD_OP_LSB +: 2]);
  assign cmd_lvl   = pwdata_i[CMD_LVL_LSB +: BYTE_W];

  // read mux
  always_comb begin
    rd_data = '0;
    rd_ok   = 1'b1;
    if (paddr_i == ADDR_CTRL) begin
      rd_data[UNIT_W-1:0] = unit_ff;
    end else if (paddr_i == ADDR_CMD) begin
      rd_data = '0;
    end else if (paddr_i == ADDR_STAT) begin
      rd_data = {has_def, 8'h00, armed_ff, irq_req_ff, 2'h0, irq_ch_ff};
    end else if (hit_ch) begin
      case (a_reg)
        CH_LVL:   rd_data = {16'h0000, ret_ff[a_ch], lvl_ff[a_ch]};
        CH_SCAN:  rd_data = {8'h00, saved_ff[a_ch], mask_ff[a_ch],
                             flags_ff[a_ch]};
        CH_STAT:  rd_data = {24'h000000, stat_ff[a_ch]};
        default:  rd_data = {30'h00000000, defer_ff[a_ch]};
      endcase
    end else if (hit_line) begin
      rd_data = {24'h000000, lctl_ff[a_line]};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // one wait state so every bus output comes from a flop
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= '0;
      pslverr_ff <= 1'b0;
    end else if (psel_i && penable_i && !pready_ff) begin
      pready_ff  <= 1'b1;
      prdata_ff  <= pwrite_i ? 32'h00000000 : rd_data;
      pslverr_ff <= !rd_ok;
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // per-channel table state
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic me_cmd;
    logic me_wr;
    logic zero_lvl;
    logic trig;
    logic scan_me;
    assign me_cmd   = cmd_wr && (cmd_ch == CH_W'(c));
    assign me_wr    = wr_en && hit_ch && (a_ch == CH_W'(c));
    assign scan_me  = chg && (sp_ff == CH_W'(c));
    // three host actions zero the level
    assign zero_lvl = init_wr || (me_cmd && ((cmd_op == CIS_OP_CHINIT) ||
                      (cmd_op == CIS_OP_INTCTL && cmd_lvl == RST_BYTE)));
    // any interrupt cause, gated by a live nonzero level
    assign trig = (lvl_ff[c] != RST_BYTE) && (
        (ccb_done_i && ccb_ch_i == CH_W'(c) && ccb_intctl_i &&
         !ccbz_ff[c])
      || (blk_done_i && blk_ch_i == CH_W'(c))
      || (program_interrupt_instruction_exec_i && program_interrupt_instruction_ch_i == CH_W'(c))
      || (scan_me && flags_ff[c][SCAN_TERM_BIT]));
    assign has_def[c] = (defer_ff[c] != '0);

    // level and return channel
    always_ff @(posedge core_clk_i) begin
      if (!rstn_i || zero_lvl) begin
        lvl_ff[c] <= RST_BYTE;
        ret_ff[c] <= (!rstn_i || init_wr) ? RST_BYTE : ret_ff[c];
      end else if (me_cmd && cmd_op == CIS_OP_INTCTL) begin
        lvl_ff[c] <= cmd_lvl;
        ret_ff[c] <= pwdata_i[CMD_RET_LSB +: BYTE_W];
      end else if (me_wr && a_reg == CH_LVL) begin
        lvl_ff[c] <= pwdata_i[7:0];
        ret_ff[c] <= pwdata_i[15:8];
      end
    end

    // remembers a zeroing during the active block
    always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
        ccbz_ff[c] <= 1'b0;
      end else if (zero_lvl) begin
        ccbz_ff[c] <= 1'b1;
      end else if (ccb_start_i && ccb_ch_i == CH_W'(c)) begin
        ccbz_ff[c] <= 1'b0;
      end
    end

    // scan bytes: software writes, a scan hit records
    always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
        flags_ff[c] <= RST_BYTE;
        mask_ff[c]  <= RST_BYTE;
        saved_ff[c] <= RST_BYTE;
        stat_ff[c]  <= RST_BYTE;
      end else begin
        if (me_wr && a_reg == CH_SCAN) begin
          flags_ff[c] <= pwdata_i[7:0];
          mask_ff[c]  <= pwdata_i[15:8];
          saved_ff[c] <= pwdata_i[23:16];
        end
        if (me_wr && a_reg == CH_STAT) begin
          stat_ff[c] <= pwdata_i[7:0];
        end
        // hardware update last so a set beats a same-cycle write
        if (scan_me) begin
          saved_ff[c] <= live;
          if (flags_ff[c][SCAN_FLAG_BIT]) begin
            stat_ff[c][STAT_CHG_BIT] <= 1'b1;
          end
        end
      end
    end

    // new request flag, set wins over the grant
    always_ff @(posedge core_clk_i) begin
      if (!rstn_i || init_wr) begin
        fresh_ff[c] <= 1'b0;
      end else if (trig) begin
        fresh_ff[c] <= 1'b1;
      end else if (irq_st_ff == CIS_IRQ_IDLE && pick_f[CH_W] &&
                   pick_f[CH_W-1:0] == CH_W'(c)) begin
        fresh_ff[c] <= 1'b0;
      end
    end

    // deferred queue depth
    always_ff @(posedge core_clk_i) begin
      if (!rstn_i || init_wr ||
          (me_cmd && cmd_op == CIS_OP_CHINIT)) begin
        defer_ff[c] <= '0;
      end else if (irq_done && irq_ch_ff == CH_W'(c)) begin
        if (irq_nak_i && is_fresh_ff &&
            defer_ff[c] != DEFER_W'(DEFER_MAX)) begin
          defer_ff[c] <= defer_ff[c] + 1'b1;
        end else if (irq_ack_i && !is_fresh_ff && has_def[c]) begin
          defer_ff[c] <= defer_ff[c] - 1'b1;
        end
        // a refusal against a full queue is dropped
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt sequencer
  // ----------------------------------------------------------------
  // new requests go first; a queue only retries once armed
  assign pick_f   = cis_pick(fresh_ff, '0);
  assign pick_d   = cis_pick(has_def, rr_ff);
  assign irq_done = (irq_st_ff == CIS_IRQ_WAIT) &&
                    (irq_ack_i || irq_nak_i);

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || init_wr) begin
      irq_st_ff   <= CIS_IRQ_IDLE;
      irq_req_ff  <= 1'b0;
      irq_lvl_ff  <= RST_BYTE;
      irq_ret_ff  <= RST_BYTE;
      irq_ch_ff   <= '0;
      is_fresh_ff <= 1'b0;
    end else begin
      case (irq_st_ff)
        CIS_IRQ_IDLE: begin
          if (pick_f[CH_W]) begin
            irq_st_ff   <= CIS_IRQ_WAIT;
            irq_req_ff  <= 1'b1;
            irq_ch_ff   <= pick_f[CH_W-1:0];
            irq_lvl_ff  <= lvl_ff[pick_f[CH_W-1:0]];
            irq_ret_ff  <= ret_ff[pick_f[CH_W-1:0]];
            is_fresh_ff <= 1'b1;
          end else if (armed_ff && pick_d[CH_W]) begin
            irq_st_ff   <= CIS_IRQ_WAIT;
            irq_req_ff  <= 1'b1;
            irq_ch_ff   <= pick_d[CH_W-1:0];
            irq_lvl_ff  <= lvl_ff[pick_d[CH_W-1:0]];
            irq_ret_ff  <= ret_ff[pick_d[CH_W-1:0]];
            is_fresh_ff <= 1'b0;
          end
        end
        CIS_IRQ_WAIT: begin
          if (irq_done) begin
            irq_st_ff  <= CIS_IRQ_IDLE;
            irq_req_ff <= 1'b0;
          end
        end
        default: begin
          irq_st_ff  <= CIS_IRQ_IDLE;
          irq_req_ff <= 1'b0;
        end
      endcase
    end
  end

  // retry arming and round-robin pointer
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || init_wr) begin
      armed_ff <= 1'b0;
      rr_ff    <= '0;
    end else if (lvlchg_wr) begin
      armed_ff <= 1'b1;
      rr_ff    <= '0;
    end else begin
      if (irq_done && !is_fresh_ff) begin
        rr_ff <= irq_ch_ff + 1'b1;
      end
      if (irq_st_ff == CIS_IRQ_IDLE && !pick_d[CH_W]) begin
        armed_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // background status scan
  // ----------------------------------------------------------------
  // one channel per tick keeps each line well inside the period
  assign tick = (tick_cnt_ff == 32'(SCAN_TICK - 1));
  assign live = adp_s2_ff[sp_ff[CH_W-1:1]*BYTE_W +: BYTE_W];
  assign chg  = tick && flags_ff[sp_ff][SCAN_EN_BIT] &&
                (((saved_ff[sp_ff] ^ live) & mask_ff[sp_ff]) != '0);

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      tick_cnt_ff <= '0;
      sp_ff       <= '0;
    end else if (tick) begin
      tick_cnt_ff <= '0;
      sp_ff       <= sp_ff + 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
    end
  end

  // scan actions out as one-cycle pulses
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      ccb_term_ff   <= 1'b0;
      prog_start_ff <= 1'b0;
      scan_ch_ff    <= '0;
    end else begin
      ccb_term_ff   <= chg && flags_ff[sp_ff][SCAN_TERM_BIT];
      prog_start_ff <= chg && flags_ff[sp_ff][SCAN_START_BIT] &&
                       !flags_ff[sp_ff][SCAN_TERM_BIT];
      if (chg) begin
        scan_ch_ff <= sp_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // line control path
  // ----------------------------------------------------------------
  for (genvar l = 0; l < NUM_LINE; l++) begin : g_line
    always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
        lctl_ff[l] <= RST_BYTE;
      end else if (wr_en && hit_line && a_line == LINE_W'(l)) begin
        lctl_ff[l] <= pwdata_i[7:0];
      end
    end
    // both channels of the line share this output
    always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
        adp_ctrl_ff[l*BYTE_W +: BYTE_W] <= RST_BYTE;
      end else if (load_ff && load_line_ff == LINE_W'(l)) begin
        adp_ctrl_ff[l*BYTE_W +: BYTE_W] <= work_ff;
      end
    end
  end

  // byte copied into the working register, applied next cycle
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      load_ff      <= 1'b0;
      load_line_ff <= '0;
      work_ff      <= RST_BYTE;
    end else begin
      load_ff <= wr_en && (paddr_i == ADDR_CTRL) &&
                 pwdata_i[CTRL_LOAD_BIT];
      if (wr_en && (paddr_i == ADDR_CTRL) && pwdata_i[CTRL_LOAD_BIT]) begin
        load_line_ff <= pwdata_i[CTRL_LINE_LSB +: LINE_W];
        work_ff      <= lctl_ff[pwdata_i[CTRL_LINE_LSB +: LINE_W]];
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pready_o     = pready_ff;
  assign prdata_o     = prdata_ff;
  assign pslverr_o    = pslverr_ff;
  assign irq_req_o    = irq_req_ff;
  assign irq_lvl_o    = irq_lvl_ff;
  assign irq_ret_o    = irq_ret_ff;
  assign irq_ch_o     = irq_ch_ff;
  assign ccb_term_o   = ccb_term_ff;
  assign prog_start_o = prog_start_ff;
  assign scan_ch_o    = scan_ch_ff;
  assign adp_ctrl_o   = adp_ctrl_ff;

endmodule
`default_nettype wire

/* File: test/cis_core_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------
// port checker
// ----------------
module cis_core_chk
  import cis_pkg::*;
(
  input wire logic core_clk_i, rstn_i, psel_i, penable_i, pwrite_i,
  input wire logic pready_o, irq_ack_i, irq_nak_i, irq_req_o,
  input wire logic ccb_term_o, prog_start_o,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [BYTE_W-1:0] irq_lvl_o, irq_ret_o,
  input wire logic [CH_W-1:0] irq_ch_o,
  input wire logic [NUM_LINE*BYTE_W-1:0] adp_ctrl_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  chk_req_hold: assert property (
    irq_req_o && !irq_ack_i && !irq_nak_i |=> irq_req_o
    && $stable({irq_ch_o, irq_lvl_o, irq_ret_o})) else $error("irq moved");
  chk_req_drop: assert property (
    irq_req_o && (irq_ack_i || irq_nak_i) |=> !irq_req_o)
    else $error("irq kept");
  chk_lvl_nonzero: assert property (
    irq_req_o |-> irq_lvl_o != 8'h00) else $error("irq at level zero");
  chk_term_pulse: assert property (
    ccb_term_o |=> !ccb_term_o) else $error("terminate too long");
  chk_start_pulse: assert property (
    prog_start_o |=> !prog_start_o) else $error("start too long");
  chk_start_excl: assert property (
    ccb_term_o |-> !prog_start_o) else $error("start with terminate");
  chk_apb_wait: assert property (
    psel_i && $rose(penable_i) |=> pready_o ##1 !pready_o)
    else $error("bad apb answer");
  // adapter control moves only two cycles after a load request
  chk_ctrl_load: assert property (
    !$stable(adp_ctrl_o) |-> $past(psel_i && penable_i && pready_o
    && pwrite_i && paddr_i == ADDR_CTRL && pwdata_i[CTRL_LOAD_BIT], 2))
    else $error("adapter control moved");
  cov_nak: cover property (irq_req_o && irq_nak_i);
  cov_term: cover property (ccb_term_o);
  cov_start: cover property (prog_start_o);
endmodule
bind cis_core cis_core_chk u_chk (.*);
`default_nettype wire

/* File: test/cis_host_mdl.sv */
`timescale 1ns/1ps
`default_nettype none
// host answers after dly_i cycles; refuses lower-priority levels
module cis_host_mdl (
  input  wire logic       clk_i, rstn_i, req_i,
  input  wire logic [7:0] lvl_i, run_lvl_i, dly_i,
  output logic            ack_o, nak_o
);
  logic [7:0] cnt_ff; // cycles since the request rose
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !req_i || ack_o || nak_o) begin
      cnt_ff <= 8'h00;
      ack_o <= 1'b0;
      nak_o <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
      ack_o <= cnt_ff == dly_i && lvl_i <= run_lvl_i;
      nak_o <= cnt_ff == dly_i && lvl_i > run_lvl_i;
    end
  end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
  import cis_pkg::*;
;
  logic core_clk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic ccb_start_i = 0, ccb_done_i = 0, ccb_intctl_i = 0, blk_done_i = 0;
  logic program_interrupt_instruction_exec_i = 0, pready_o, pslverr_o, irq_req_o, irq_ack_i, irq_nak_i;
  logic ccb_term_o, prog_start_o, req_d = 0, se;
  logic [ADDR_W-1:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd;
  logic [UNIT_W-1:0] unit_sw_i = '0;
  logic [63:0] adp_status_i = '0, adp_ctrl_o;
  logic [CH_W-1:0] ccb_ch_i = '0, blk_ch_i = '0, program_interrupt_instruction_ch_i = '0, irq_ch_o;
  logic [CH_W-1:0] scan_ch_o, c;
  logic [7:0] irq_lvl_o, irq_ret_o, run_lvl = 8'hff, dly = 8'h00, lv;
  logic [19:0] q[$]; // expected {channel, level, return}
  int err_total = 0, total_checks = 0, n_term = 0, n_start = 0;
  cis_core #(.SCAN_TICK(8)) u_cis_core (.*);
  cis_host_mdl u_cis_host_mdl (.clk_i(core_clk_i), .rstn_i(rstn_i),
    .req_i(irq_req_o), .lvl_i(irq_lvl_o), .run_lvl_i(run_lvl),
    .dly_i(dly), .ack_o(irq_ack_i), .nak_o(irq_nak_i));
  always #10 core_clk_i = ~core_clk_i;
  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic end_of_test;
    if (err_total == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one apb transfer, then an idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge core_clk_i) penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1 && ++n < 40);
    rd = prdata_o;
    se = pslverr_o;
    if (n >= 40) begin chk("apb", 0, 1); end_of_test; end
    psel_i <= 1'b0; penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m, e);
    apb(1'b0, a, '0);
    chk(nm, rd & m, e);
  endtask
  task automatic cmd(input logic [3:0] ch, input logic [7:0] l,
                     input logic [1:0] op, input logic [5:0] u);
    apb(1'b1, ADDR_CMD, {8'ha0 | ch, l, 4'h0, op, u, ch});
  endtask
  task automatic nt(input logic [3:0] ch, input logic [7:0] l);
    q.push_back({ch, l, 8'ha0 | ch});
  endtask
  // bounded wait: all expected interrupts seen, request low
  task automatic wq;
    int n;
    n = 0;
    repeat (6) @(posedge core_clk_i);
    while ((q.size() != 0 || irq_req_o !== 1'b0) && ++n < 400) @(posedge core_clk_i);
    if (n >= 400) begin chk("wait", 0, 1); end_of_test; end
  endtask
  // k: 0 block start, 1 block end, 2 block mode done, 3 program interrupt
  task automatic ev(input int k, input logic [3:0] ch, input logic ic);
    ccb_ch_i <= ch; blk_ch_i <= ch; program_interrupt_instruction_ch_i <= ch; ccb_intctl_i <= ic;
    ccb_start_i <= k == 0; ccb_done_i <= k == 1;
    blk_done_i <= k == 2; program_interrupt_instruction_exec_i <= k == 3;
    dly <= 8'($urandom_range(0, 6)); // prompt and slow host
    @(posedge core_clk_i);
    {ccb_start_i, ccb_done_i, blk_done_i, program_interrupt_instruction_exec_i} <= 4'h0;
    wq;
  endtask
  // monitor: each rising request takes the oldest note
  always @(posedge core_clk_i) begin
    n_term += int'(ccb_term_o === 1'b1);
    n_start += int'(prog_start_o === 1'b1);
    if (irq_req_o === 1'b1 && !req_d)
      chk("irq", {irq_ch_o, irq_lvl_o, irq_ret_o}, q.size() ? q.pop_front() : 'x);
    req_d = irq_req_o === 1'b1;
  end
  initial begin
    void'($urandom(32'hd8a162bb));
    @(posedge core_clk_i) unit_sw_i <= 6'($urandom);
    repeat (4) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    @(posedge core_clk_i);
    rdc("unit", ADDR_CTRL, 32'h3f, {26'h0, unit_sw_i});
    rdc("hole", 12'hff0, '1, '0);
    chk("slverr", se, 1'b1);
    for (int i = 0; i < 16; i++) cmd(4'(i), 8'(i + 1), 2'h0, unit_sw_i);
    c = 4'(10 + $urandom_range(0, 5));
    lv = 8'(c + 1);
    rdc("level", {4'h1, c, 4'h0}, 32'hffff, {16'h0, 8'ha0 | c, lv});
    for (int k = 0; k < 4; k++) begin
      if (k > 0) nt(c, lv);
      ev(k, c, 1'b1);
    end
    ev(0, c, 1'b0);
    ev(1, c, 1'b0);
    cmd(c, 8'h00, 2'h0, ~unit_sw_i);
    nt(c, lv);
    ev(3, c, 1'b1);
    ev(0, c, 1'b1);
    cmd(c, 8'h00, 2'h0, unit_sw_i);
    ev(3, c, 1'b1);
    cmd(c, lv, 2'h0, unit_sw_i);
    ev(1, c, 1'b1);
    cmd(c, lv, 2'h1, unit_sw_i);
    rdc("chinit", {4'h1, c, 4'h0}, 32'hff, 32'h0);
    run_lvl <= 8'h01;
    repeat (4) begin
      nt(4'h4, 8'h05);
      ev(3, 4'h4, 1'b1);
    end
    nt(4'h9, 8'h0a);
    ev(3, 4'h9, 1'b1);
    rdc("defer", 12'h14c, 32'h3, 32'h3);
    rdc("stat", ADDR_STAT, 32'hffff0000, 32'h02100000);
    run_lvl <= 8'hff;
    nt(4'h4, 8'h05); nt(4'h9, 8'h0a); nt(4'h4, 8'h05); nt(4'h4, 8'h05);
    apb(1'b1, ADDR_CTRL, 32'h2);
    wq;
    rdc("drain", 12'h14c, 32'h3, 32'h0);
    lv = (8'($urandom) | 8'h01) & 8'h7f; // inverse never zero
    apb(1'b1, 12'h124, 32'h00ff07);
    nt(4'h2, 8'h03);
    adp_status_i[15:8] <= lv;
    repeat (200) @(posedge core_clk_i); // more than one full scan round of 128 cycles
    wq;
    chk("term", n_term, 1);
    chk("scanch", scan_ch_o, 4'h2);
    rdc("saved", 12'h124, 32'hff0000, {8'h0, lv, 16'h0});
    rdc("flag", 12'h128, 32'h8, 32'h8);
    apb(1'b1, 12'h124, {8'h0, lv, 16'hff00});
    apb(1'b1, 12'h134, 32'h00ff09);
    adp_status_i[15:8] <= ~lv;
    repeat (200) @(posedge core_clk_i);
    chk("start", n_start, 1);
    chk("scanch", scan_ch_o, 4'h3);
    chk("off", n_term, 1);
    lv = 8'($urandom);
    apb(1'b1, {4'h2, 3'h0, c[2:0], 2'h0}, {24'h0, lv});
    apb(1'b1, ADDR_CTRL, {25'h0, c[2:0], 4'h4});
    @(posedge core_clk_i);
    chk("adp", adp_ctrl_o[8*c[2:0] +: 8], lv);
    apb(1'b1, ADDR_CTRL, 32'h1);
    ev(3, 4'h4, 1'b1);
    rdc("uinit", 12'h140, 32'hff, 32'h0);
    end_of_test;
  end
endmodule
`default_nettype wire
